// ===== shr_map.svh
`ifndef SHR_MAP_SVH
`define SHR_MAP_SVH

// Register indices; the byte address on the bus is four times the index.
`define SHR_IDX_TXDATA   6'h00
`define SHR_IDX_STATUS   6'h01
`define SHR_IDX_RXDATA   6'h02
`define SHR_IDX_CFG      6'h3b

// Rate configuration layout and reset value.
`define SHR_CFG_RESET    8'h7a
`define SHR_EXP_MSB      7
`define SHR_EXP_LSB      5
`define SHR_MANT_MSB     4
`define SHR_MANT_LSB     0
`define SHR_EXP0_ADD     13'h0001
`define SHR_EXPN_ADD     13'h0021
`define SHR_EXP_ONE      3'h1

// Status register bit positions.
`define SHR_ST_TX_BUSY   0
`define SHR_ST_RX_VALID  1
`define SHR_ST_FRAME_ERR 2
`define SHR_ST_OVERRUN   3

// Character framing: index of the last data bit.
`define SHR_LAST_BIT     3'h7

// Reference rate and system clock rate, both in kHz.
`define SHR_REF_KHZ      17'h069f0
`define SHR_CLK_KHZ      17'h09c40

`endif

// ===== shr_pkg.sv
package shr_pkg;

    typedef enum logic [1:0]
    {
        SHR_IDLE  = 2'b00,
        SHR_START = 2'b01,
        SHR_DATA  = 2'b10,
        SHR_STOP  = 2'b11
    } shr_state_t;

endpackage

// ===== shr_bit_timer.sv
`timescale 1ns/1ps

// ==========================================================
// Bit period timer counting reference ticks.
module shr_bit_timer
#(
    parameter int DIV_W = 13
)
(
    // Clock and reset
    input  wire logic             sys_clk,
    input  wire logic             resetn,
    // Timing control
    input  wire logic             ref_tick,
    input  wire logic             restart,
    input  wire logic             half_first,
    input  wire logic [DIV_W-1:0] divisor,
    // Bit boundary pulse
    output logic                  bit_tick
);

    logic [DIV_W-1:0] cnt_q;
    logic [DIV_W-1:0] cnt_d;

    // The compare is >= so that a divisor lowered mid-bit still ends the bit.
    always_comb
    begin
        cnt_d    = cnt_q;
        bit_tick = 1'b0;
        if (restart)
        begin
            cnt_d = half_first ? (divisor >> 1) : '0;
        end
        else if (ref_tick)
        begin
            if (cnt_q >= divisor - 1'b1)
            begin
                cnt_d    = '0;
                bit_tick = 1'b1;
            end
            else
            begin
                cnt_d = cnt_q + 1'b1;
            end
        end
    end

    always_ff @(posedge sys_clk or negedge resetn)
    begin
        if (!resetn)
            cnt_q <= '0;
        else
            cnt_q <= cnt_d;
    end

endmodule

// ===== shr_top.sv
`timescale 1ns/1ps
`include "shr_map.svh"

module shr_top
(
    // Clock and reset
    input  wire logic        sys_clk,
    input  wire logic        resetn,
    // APB slave
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic [31:0]      prdata,
    output logic             pready,
    output logic             pslverr,
    // Serial link
    input  wire logic        ser_rx,
    output logic             ser_tx
);

    // ==========================================================
    // Decoding helpers.
    function automatic logic addr_hit(input logic [7:0] addr, input logic [5:0] idx);
        addr_hit = (addr[1:0] == 2'h0) && (addr[7:2] == idx);
    endfunction

    function automatic logic [12:0] rate_divisor(input logic [7:0] cfg);
        logic [2:0]  exp_f;
        logic [12:0] base;
        exp_f = cfg[`SHR_EXP_MSB:`SHR_EXP_LSB];
        base  = {8'h00, cfg[`SHR_MANT_MSB:`SHR_MANT_LSB]};
        if (exp_f == 3'h0)
            rate_divisor = base + `SHR_EXP0_ADD;
        else
            rate_divisor = 13'((base + `SHR_EXPN_ADD) << (exp_f - `SHR_EXP_ONE));
    endfunction

    // ==========================================================
    // Reference tick: 27.12 MHz average rate from the 40 MHz clock.
    logic [16:0] nco_q;
    logic [16:0] nco_d;
    logic        ref_tick;

    always_comb
    begin
        ref_tick = (nco_q + `SHR_REF_KHZ) >= `SHR_CLK_KHZ;
        nco_d    = ref_tick ? (nco_q + `SHR_REF_KHZ - `SHR_CLK_KHZ) : (nco_q + `SHR_REF_KHZ);
    end

    always_ff @(posedge sys_clk or negedge resetn)
    begin
        if (!resetn)
            nco_q <= '0;
        else
            nco_q <= nco_d;
    end

    // ==========================================================
    // Register access.
    logic        wr_acc;
    logic        rd_acc;
    logic        setup;
    logic        hit;
    logic [7:0]  cfg_q;
    logic [7:0]  cfg_d;
    logic [31:0] prdata_q;
    logic [31:0] prdata_d;
    logic [12:0] divisor;
    logic        tx_start;
    logic        rd_rxdata;
    logic        clr_frame;
    logic        clr_overrun;
    logic [7:0]  rx_data_q;
    logic        rx_valid_q;
    logic        frame_err_q;
    logic        overrun_q;
    shr_pkg::shr_state_t tx_state_q;

    assign hit     = addr_hit(paddr, `SHR_IDX_TXDATA) || addr_hit(paddr, `SHR_IDX_STATUS)
                  || addr_hit(paddr, `SHR_IDX_RXDATA) || addr_hit(paddr, `SHR_IDX_CFG);
    assign setup   = psel && !penable;
    assign wr_acc  = psel && penable && pwrite;
    assign rd_acc  = psel && penable && !pwrite;
    assign pready  = 1'b1;
    assign pslverr = psel && penable && !hit;
    assign prdata  = prdata_q;
    assign divisor = rate_divisor(cfg_q);

    assign tx_start    = wr_acc && addr_hit(paddr, `SHR_IDX_TXDATA) && (tx_state_q == shr_pkg::SHR_IDLE);
    assign rd_rxdata   = rd_acc && addr_hit(paddr, `SHR_IDX_RXDATA);
    assign clr_frame   = wr_acc && addr_hit(paddr, `SHR_IDX_STATUS) && pwdata[`SHR_ST_FRAME_ERR];
    assign clr_overrun = wr_acc && addr_hit(paddr, `SHR_IDX_STATUS) && pwdata[`SHR_ST_OVERRUN];

    always_comb
    begin
        cfg_d    = cfg_q;
        prdata_d = prdata_q;
        if (wr_acc && addr_hit(paddr, `SHR_IDX_CFG))
            cfg_d = pwdata[7:0];
        // Read data is captured in the setup cycle so the access phase can complete at once.
        if (setup)
        begin
            prdata_d = 32'h0000_0000;
            if (addr_hit(paddr, `SHR_IDX_CFG))
                prdata_d[7:0] = cfg_q;
            else if (addr_hit(paddr, `SHR_IDX_RXDATA))
                prdata_d[7:0] = rx_data_q;
            else if (addr_hit(paddr, `SHR_IDX_STATUS))
            begin
                prdata_d[`SHR_ST_TX_BUSY]   = tx_state_q != shr_pkg::SHR_IDLE;
                prdata_d[`SHR_ST_RX_VALID]  = rx_valid_q;
                prdata_d[`SHR_ST_FRAME_ERR] = frame_err_q;
                prdata_d[`SHR_ST_OVERRUN]   = overrun_q;
            end
        end
    end

    always_ff @(posedge sys_clk or negedge resetn)
    begin
        if (!resetn)
        begin
            cfg_q    <= `SHR_CFG_RESET;
            prdata_q <= 32'h0000_0000;
        end
        else
        begin
            cfg_q    <= cfg_d;
            prdata_q <= prdata_d;
        end
    end

    // ==========================================================
    // Transmitter.
    shr_pkg::shr_state_t tx_state_d;
    logic [7:0] tx_shift_q;
    logic [7:0] tx_shift_d;
    logic [2:0] tx_bit_q;
    logic [2:0] tx_bit_d;
    logic       ser_tx_q;
    logic       ser_tx_d;
    logic       tx_tick;

    shr_bit_timer #(.DIV_W(13)) u_tx_timer
    (
        .sys_clk    (sys_clk),
        .resetn     (resetn),
        .ref_tick   (ref_tick),
        .restart    (tx_state_q == shr_pkg::SHR_IDLE),
        .half_first (1'b0),
        .divisor    (divisor),
        .bit_tick   (tx_tick)
    );

    always_comb
    begin
        tx_state_d = tx_state_q;
        tx_shift_d = tx_shift_q;
        tx_bit_d   = tx_bit_q;
        ser_tx_d   = ser_tx_q;
        case (tx_state_q)
            shr_pkg::SHR_IDLE:
            begin
                ser_tx_d = 1'b1;
                if (tx_start)
                begin
                    tx_shift_d = pwdata[7:0];
                    ser_tx_d   = 1'b0;
                    tx_state_d = shr_pkg::SHR_START;
                end
            end
            shr_pkg::SHR_START:
            begin
                if (tx_tick)
                begin
                    ser_tx_d   = tx_shift_q[0];
                    tx_shift_d = tx_shift_q >> 1;
                    tx_bit_d   = 3'h0;
                    tx_state_d = shr_pkg::SHR_DATA;
                end
            end
            shr_pkg::SHR_DATA:
            begin
                if (tx_tick)
                begin
                    if (tx_bit_q == `SHR_LAST_BIT)
                    begin
                        ser_tx_d   = 1'b1;
                        tx_state_d = shr_pkg::SHR_STOP;
                    end
                    else
                    begin
                        ser_tx_d   = tx_shift_q[0];
                        tx_shift_d = tx_shift_q >> 1;
                        tx_bit_d   = tx_bit_q + 3'h1;
                    end
                end
            end
            shr_pkg::SHR_STOP:
            begin
                if (tx_tick)
                    tx_state_d = shr_pkg::SHR_IDLE;
            end
            default:
            begin
                tx_state_d = shr_pkg::SHR_IDLE;
            end
        endcase
    end

    always_ff @(posedge sys_clk or negedge resetn)
    begin
        if (!resetn)
        begin
            tx_state_q <= shr_pkg::SHR_IDLE;
            tx_shift_q <= 8'h00;
            tx_bit_q   <= 3'h0;
            ser_tx_q   <= 1'b1;
        end
        else
        begin
            tx_state_q <= tx_state_d;
            tx_shift_q <= tx_shift_d;
            tx_bit_q   <= tx_bit_d;
            ser_tx_q   <= ser_tx_d;
        end
    end

    assign ser_tx = ser_tx_q;

    // ==========================================================
    // Receiver.
    shr_pkg::shr_state_t rx_state_q;
    shr_pkg::shr_state_t rx_state_d;
    logic       rx_meta_q;
    logic       rx_sync_q;
    logic       rx_last_q;
    logic [7:0] rx_shift_q;
    logic [7:0] rx_shift_d;
    logic [2:0] rx_bit_q;
    logic [2:0] rx_bit_d;
    logic [7:0] rx_data_d;
    logic       rx_valid_d;
    logic       frame_err_d;
    logic       overrun_d;
    logic       rx_tick;

    shr_bit_timer #(.DIV_W(13)) u_rx_timer
    (
        .sys_clk    (sys_clk),
        .resetn     (resetn),
        .ref_tick   (ref_tick),
        .restart    (rx_state_q == shr_pkg::SHR_IDLE),
        .half_first (1'b1),
        .divisor    (divisor),
        .bit_tick   (rx_tick)
    );

    // Clears are applied first so that an event in the same cycle wins.
    always_comb
    begin
        rx_state_d  = rx_state_q;
        rx_shift_d  = rx_shift_q;
        rx_bit_d    = rx_bit_q;
        rx_data_d   = rx_data_q;
        rx_valid_d  = rx_valid_q && !rd_rxdata;
        frame_err_d = frame_err_q && !clr_frame;
        overrun_d   = overrun_q && !clr_overrun;
        case (rx_state_q)
            shr_pkg::SHR_IDLE:
            begin
                // A falling edge is needed, so a line held low after a bad stop bit does not restart reception.
                if (rx_last_q && !rx_sync_q)
                    rx_state_d = shr_pkg::SHR_START;
            end
            shr_pkg::SHR_START:
            begin
                if (rx_tick)
                begin
                    rx_bit_d   = 3'h0;
                    rx_state_d = rx_sync_q ? shr_pkg::SHR_IDLE : shr_pkg::SHR_DATA;
                end
            end
            shr_pkg::SHR_DATA:
            begin
                if (rx_tick)
                begin
                    rx_shift_d = {rx_sync_q, rx_shift_q[7:1]};
                    rx_bit_d   = rx_bit_q + 3'h1;
                    if (rx_bit_q == `SHR_LAST_BIT)
                        rx_state_d = shr_pkg::SHR_STOP;
                end
            end
            shr_pkg::SHR_STOP:
            begin
                if (rx_tick)
                begin
                    rx_state_d = shr_pkg::SHR_IDLE;
                    if (rx_sync_q)
                    begin
                        rx_data_d  = rx_shift_q;
                        rx_valid_d = 1'b1;
                        if (rx_valid_q && !rd_rxdata)
                            overrun_d = 1'b1;
                    end
                    else
                    begin
                        frame_err_d = 1'b1;
                    end
                end
            end
            default:
            begin
                rx_state_d = shr_pkg::SHR_IDLE;
            end
        endcase
    end

    always_ff @(posedge sys_clk or negedge resetn)
    begin
        if (!resetn)
        begin
            rx_meta_q   <= 1'b1;
            rx_sync_q   <= 1'b1;
            rx_last_q   <= 1'b1;
            rx_state_q  <= shr_pkg::SHR_IDLE;
            rx_shift_q  <= 8'h00;
            rx_bit_q    <= 3'h0;
            rx_data_q   <= 8'h00;
            rx_valid_q  <= 1'b0;
            frame_err_q <= 1'b0;
            overrun_q   <= 1'b0;
        end
        else
        begin
            rx_meta_q   <= ser_rx;
            rx_sync_q   <= rx_meta_q;
            rx_last_q   <= rx_sync_q;
            rx_state_q  <= rx_state_d;
            rx_shift_q  <= rx_shift_d;
            rx_bit_q    <= rx_bit_d;
            rx_data_q   <= rx_data_d;
            rx_valid_q  <= rx_valid_d;
            frame_err_q <= frame_err_d;
            overrun_q   <= overrun_d;
        end
    end

    // ==========================================================
    // Checks.
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!resetn);

    sequence s_tx_begin;
        tx_start;
    endsequence

    sequence s_start_low;
        !ser_tx [*2];
    endsequence

    AST_DIV_EXP0: assert property (cfg_q[7:5] == 3'h0 |-> divisor == {8'h00, cfg_q[4:0]} + 13'h0001)
        else $error("Divisor wrong for zero exponent.");
    AST_DIV_EXPN: assert property (cfg_q == 8'h3a |-> divisor == 13'h003b)
        else $error("Divisor wrong for nonzero exponent.");
    AST_TABLE_RATES: assert property ((cfg_q == 8'heb |-> divisor == 13'h0b00)
                                      and (cfg_q == 8'h15 |-> divisor == 13'h0016))
        else $error("Table rate setting gives wrong divisor.");
    AST_TX_FRAME: assert property (s_tx_begin |=> s_start_low)
        else $error("Start bit not driven low.");
    AST_TX_STOP: assert property (tx_state_q == shr_pkg::SHR_STOP |-> ser_tx)
        else $error("Stop bit not high.");
    AST_RESET_CFG: assert property ($rose(resetn) |-> cfg_q == `SHR_CFG_RESET)
        else $error("Rate configuration reset value wrong.");
    AST_CFG_WRITE: assert property (wr_acc && addr_hit(paddr, `SHR_IDX_CFG) |=> cfg_q == $past(pwdata[7:0]))
        else $error("Rate configuration write not taken.");
    AST_RX_EDGE: assert property (rx_state_q == shr_pkg::SHR_IDLE && rx_last_q && !rx_sync_q
                                  |=> rx_state_q == shr_pkg::SHR_START)
        else $error("Start edge not detected.");

endmodule

// ===== shr_host_model.sv
`timescale 1ns/1ps

// ==========================================================
// Host side of the serial link: sends and receives characters.
module shr_host_model
(
    // Clock
    input  wire logic sys_clk,
    // Serial link
    input  wire logic ser_tx,
    output logic      ser_rx
);
    initial ser_rx = 1'b1;

    // Bit edges follow a real period in clocks, so jitter never accumulates.
    task automatic send(input logic [7:0] d, input real p, input logic stop);
        logic [9:0] f;
        f = {stop, d, 1'b0};
        @(posedge sys_clk);
        for (int i = 0; i < 10; i++)
        begin
            ser_rx <= f[i];
            repeat ($rtoi((i + 1) * p) - $rtoi(i * p)) @(posedge sys_clk);
        end
        ser_rx <= 1'b1;
    endtask

    // Samples each data bit and the stop bit at its middle, counted from the falling start edge.
    task automatic recv(input real p, output logic [7:0] d, output int len, output logic stop, output logic ok);
        int c;
        int k;
        ok = 1'b0;
        len = 0;
        c = 0;
        d = 8'h00;
        stop = 1'b0;
        for (k = 0; k < 200 && ser_tx !== 1'b0; k++) @(negedge sys_clk);
        if (ser_tx !== 1'b0)
            return;
        for (k = 0; k < 9; k++)
        begin
            while (c < $rtoi((k + 1.5) * p))
            begin
                @(negedge sys_clk);
                c++;
                if (len == 0 && ser_tx === 1'b1)
                    len = c;
            end
            if (k < 8)
                d[k] = ser_tx;
            else
                stop = ser_tx;
        end
        ok = 1'b1;
    endtask
endmodule

// ===== testbench.sv
`timescale 1ns/1ps
`include "shr_map.svh"

// ==========================================================
// Register and serial link tests of the rate generator.
module testbench;
    logic        sys_clk;
    logic        resetn;
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [7:0]  paddr;
    logic [31:0] pwdata;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    logic        ser_rx;
    logic        ser_tx;
    logic [31:0] rdv;
    logic        err;
    int          failures;
    int          checks_done;
    int          n;

    localparam logic [7:0] A_TX  = {`SHR_IDX_TXDATA, 2'b00};
    localparam logic [7:0] A_ST  = {`SHR_IDX_STATUS, 2'b00};
    localparam logic [7:0] A_RX  = {`SHR_IDX_RXDATA, 2'b00};
    localparam logic [7:0] A_CFG = {`SHR_IDX_CFG, 2'b00};
    // No setting here is faster than 1232.7 kbit/s.
    localparam logic [7:0] RATES [7] = '{8'h15, 8'h1c, 8'h74, 8'h7a, 8'h5a, 8'h3a, 8'h9a};

    shr_top dut_u
    (
        .sys_clk (sys_clk),
        .resetn  (resetn),
        .psel    (psel),
        .penable (penable),
        .pwrite  (pwrite),
        .paddr   (paddr),
        .pwdata  (pwdata),
        .prdata  (prdata),
        .pready  (pready),
        .pslverr (pslverr),
        .ser_rx  (ser_rx),
        .ser_tx  (ser_tx)
    );

    shr_host_model host_u
    (
        .sys_clk (sys_clk),
        .ser_tx  (ser_tx),
        .ser_rx  (ser_rx)
    );

    always #12.5 sys_clk = ~sys_clk;

    task automatic finish_test;
        $display("Checks %0d, mismatches %0d", checks_done, failures);
        if (failures == 0 && checks_done > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask

    task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp)
        begin
            failures++;
            $display("Error %s expected %h seen %h", name, exp, seen);
        end
    endtask

    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] wd);
        int k;
        @(posedge sys_clk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= wd;
        @(posedge sys_clk);
        penable <= 1'b1;
        for (k = 0; k < 50; k++)
        begin
            @(posedge sys_clk);
            if (pready === 1'b1)
                break;
        end
        if (k == 50)
        begin
            failures++;
            finish_test();
        end
        rdv = prdata;
        err = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic rd(input logic [7:0] a, input logic [31:0] exp, input string name);
        apb(1'b0, a, 32'h0);
        check(name, rdv, exp);
    endtask

    task automatic wait_st(input int b, input logic v, input int lim);
        for (int i = 0; i < lim; i++)
        begin
            apb(1'b0, A_ST, 32'h0);
            if (rdv[b] === v)
                return;
        end
        failures++;
        finish_test();
    endtask

    // Bit period in system clocks: reference ticks at 27.12 MHz seen from 40 MHz.
    function automatic real clk_per(input logic [7:0] cfg);
        int t;
        t = (cfg[7:5] == 3'h0) ? cfg[4:0] + 1 : (cfg[4:0] + 33) << (cfg[7:5] - 1);
        return t * 40000.0 / 27120.0;
    endfunction

    function automatic logic inr(input int len, input real p);
        return len >= $rtoi(p) - 2 && len <= $rtoi(p) + 3;
    endfunction

    task automatic tx_char(input logic [7:0] cfg, input logic [7:0] d);
        logic [7:0] got;
        int         len;
        logic       stop;
        logic       ok;
        apb(1'b1, A_CFG, {24'h0, cfg});
        rd(A_CFG, {24'h0, cfg}, "cfg_readback");
        apb(1'b1, A_TX, {24'h0, d});
        host_u.recv(clk_per(cfg), got, len, stop, ok);
        check("tx_started", ok, 1'b1);
        if (ok !== 1'b1)
            finish_test();
        check("tx_data", got, d);
        check("tx_stop", stop, 1'b1);
        check("tx_bit_period", inr(len, clk_per(cfg)), 1'b1);
        wait_st(`SHR_ST_TX_BUSY, 1'b0, 400);
    endtask

    initial
    begin
        sys_clk = 1'b0;
        resetn  = 1'b0;
        psel    = 1'b0;
        penable = 1'b0;
        pwrite  = 1'b0;
        paddr   = 8'h00;
        pwdata  = 32'h0;
        failures = 0;
        checks_done = 0;
        repeat (4) @(posedge sys_clk);
        resetn <= 1'b1;
        rd(A_CFG, 32'h7a, "cfg_reset");
        rd(A_ST, 32'h0, "status_reset");
        apb(1'b0, 8'h40, 32'h0);
        check("unmapped_err", err, 1'b1);
        check("unmapped_data", rdv, 32'h0);
        $display("Test reset and map done");
        foreach (RATES[i]) tx_char(RATES[i], {RATES[i][6:0], 1'b1});
        $display("Test rate table done");
        apb(1'b1, A_CFG, 32'heb);
        apb(1'b1, A_TX, 32'h01);
        n = 0;
        for (int k = 0; k < 200 && ser_tx !== 1'b0; k++) @(negedge sys_clk);
        while (ser_tx === 1'b0 && n < 6000)
        begin
            @(negedge sys_clk);
            n++;
        end
        check("slow_bit_period", inr(n, clk_per(8'heb)), 1'b1);
        apb(1'b1, A_CFG, 32'h15);
        apb(1'b0, A_ST, 32'h0);
        check("busy_mid_char", rdv[`SHR_ST_TX_BUSY], 1'b1);
        wait_st(`SHR_ST_TX_BUSY, 1'b0, 150);
        $display("Test rate change done");
        host_u.send(8'h3c, clk_per(8'h15), 1'b1);
        wait_st(`SHR_ST_RX_VALID, 1'b1, 20);
        rd(A_RX, 32'h3c, "rx_data");
        rd(A_ST, 32'h0, "rx_valid_clear");
        host_u.send(8'h81, clk_per(8'h15), 1'b0);
        wait_st(`SHR_ST_FRAME_ERR, 1'b1, 20);
        rd(A_ST, 32'h04, "frame_err");
        apb(1'b1, A_ST, 32'h04);
        rd(A_ST, 32'h0, "frame_err_clear");
        host_u.send(8'h11, clk_per(8'h15), 1'b1);
        host_u.send(8'h22, clk_per(8'h15), 1'b1);
        wait_st(`SHR_ST_OVERRUN, 1'b1, 20);
        rd(A_ST, 32'h0a, "overrun");
        rd(A_RX, 32'h22, "rx_overwrite");
        apb(1'b1, A_ST, 32'h08);
        rd(A_ST, 32'h0, "overrun_clear");
        $display("Test receive done");
        finish_test();
    end
endmodule
